/* hdl/wdc_pkg.sv */
/*
 * Shared constants for the waveform configuration register bank:
 * register offsets, reset values, field positions and datapath widths.
 * Assumes a single converter clock domain and 16-bit register words.
 */
package wdc_pkg;

  // Register offsets on the synchronous register port
  localparam logic [15:0] ADDR_WAVE   = 16'h0027;
  localparam logic [15:0] ADDR_CONST  = 16'h0031;
  localparam logic [15:0] ADDR_GAIN   = 16'h0035;
  localparam logic [15:0] ADDR_SAW    = 16'h0037;
  localparam logic [15:0] ADDR_TWH    = 16'h003E;
  localparam logic [15:0] ADDR_TWL    = 16'h003F;
  localparam logic [15:0] ADDR_PHASE  = 16'h0043;
  localparam logic [15:0] ADDR_TRIG   = 16'h0044;
  localparam logic [15:0] ADDR_SYNTH  = 16'h0045;
  localparam logic [15:0] ADDR_MERGE  = 16'h0047;

  // Reset values
  localparam logic [15:0] RST_WAVE    = 16'h0101;
  localparam logic [15:0] RST_CONST   = 16'h0000;
  localparam logic [15:0] RST_GAIN    = 16'h0000;
  localparam logic [15:0] RST_SAW     = 16'h0104;
  localparam logic [15:0] RST_TWH     = 16'h0000;
  localparam logic [15:0] RST_TWL     = 16'h0000;
  localparam logic [15:0] RST_PHASE   = 16'h0000;
  localparam logic [15:0] RST_TRIG    = 16'h0000;
  localparam logic [15:0] RST_SYNTH   = 16'h0000;
  localparam logic [15:0] RST_MERGE   = 16'h0000;

  // Field positions
  localparam int CONST_MSB   = 15;
  localparam int CONST_LSB   = 4;
  localparam int GAIN_MSB    = 15;
  localparam int GAIN_LSB    = 4;
  localparam int STEP_MSB    = 7;
  localparam int STEP_LSB    = 2;
  localparam int SHAPE_MSB   = 1;
  localparam int SHAPE_LSB   = 0;
  localparam int TWL_MSB     = 15;
  localparam int TWL_LSB     = 8;
  localparam int BWSEL_MSB   = 5;
  localparam int BWSEL_LSB   = 4;
  localparam int SHIFT_MSB   = 4;
  localparam int SHIFT_LSB   = 0;
  localparam int DLY_FIRST_BIT  = 1;
  localparam int COS_BIT        = 3;
  localparam int ADDR_MSB_BIT   = 2;
  localparam int PHASE_MEM_BIT  = 1;
  localparam int TW_MEM_BIT     = 0;

  // Datapath widths and scaling
  localparam int SAMPLE_W  = 14;
  localparam int TW_W      = 24;
  localparam int PH_W      = 16;
  localparam int MEM_W     = 14;
  localparam int GAIN_W    = 12;
  localparam int GAIN_FRAC = 10;
  localparam logic [4:0]  MERGE_MAX   = 5'h10;
  localparam logic [13:0] LFSR_SEED   = 14'h0001;
  localparam logic [13:0] LFSR_TAPS   = 14'h2A00;
  localparam logic [13:0] RAMP_MID    = 14'h2000;
  localparam logic [13:0] RAMP_TOP    = 14'h3FFF;
  localparam logic [15:0] COS_SHIFT   = 16'h4000;
  localparam logic [15:0] HALF_TURN   = 16'h8000;

  typedef enum logic [1:0] {
    WDC_WAVE_CONST,
    WDC_WAVE_RAMP,
    WDC_WAVE_NOISE,
    WDC_WAVE_SYNTH
  } wdc_wave_t;

  typedef enum logic [1:0] {
    WDC_SHAPE_UP,
    WDC_SHAPE_DOWN,
    WDC_SHAPE_TRI,
    WDC_SHAPE_ZERO
  } wdc_shape_t;

endpackage

/* hdl/wdc_ramp.sv */
/*
 * Sawtooth generator: rising, falling or triangle ramp, or zero.
 * Assumes step and shape come from registers in the same clock domain.
 */
`timescale 1ns/1ns
module wdc_ramp (
  input  wire logic                          CLK,
  input  wire logic                          RESET,
  input  wire logic [5:0]                    step,
  input  wire logic [1:0]                    shape,
  output wire logic signed [wdc_pkg::SAMPLE_W-1:0] level_out
);
  typedef struct packed {
    logic [5:0]  hold;
    logic [13:0] level;
    logic        down;
    logic [13:0] out;
  } wdc_ramp_t;

  wdc_ramp_t st;
  wdc_ramp_t next_st;

  always_comb begin
    next_st = st;
    // A step of zero would stall the ramp, so it acts as one
    if ((st.hold + 6'h01 >= step) || (step == 6'h00)) begin
      next_st.hold = 6'h00;
      case (wdc_pkg::wdc_shape_t'(shape))
        wdc_pkg::WDC_SHAPE_UP: next_st.level = st.level + 14'h0001;
        wdc_pkg::WDC_SHAPE_DOWN: next_st.level = st.level - 14'h0001;
        wdc_pkg::WDC_SHAPE_TRI: begin
          if (st.down) begin
            next_st.level = st.level - 14'h0001;
            if (st.level == 14'h0001) next_st.down = 1'b0;
          end else begin
            next_st.level = st.level + 14'h0001;
            if (st.level == wdc_pkg::RAMP_TOP - 14'h0001) next_st.down = 1'b1;
          end
        end
        default: next_st.level = 14'h0000;
      endcase
    end else begin
      next_st.hold = st.hold + 6'h01;
    end
    // Offset binary to two's complement around mid-scale
    if (shape == 2'h3) next_st.out = 14'h0000;
    else next_st.out = st.level ^ wdc_pkg::RAMP_MID;
  end

  always_ff @(posedge CLK) begin
    if (RESET) st <= '0;
    else st <= next_st;
  end

  assign level_out = signed'(st.out);
endmodule

/* hdl/wdc_dds.sv */
/*
 * Phase accumulator and sine/cosine shaper.
 * Assumes tuning word and offset are already selected and registered.
 * The shaper is a parabolic approximation, not a lookup table: cheap,
 * but with harmonic content well above a true table.
 */
`timescale 1ns/1ns
module wdc_dds (
  input  wire logic                              CLK,
  input  wire logic                              RESET,
  input  wire logic [wdc_pkg::TW_W-1:0]          tuning_word,
  input  wire logic [wdc_pkg::PH_W-1:0]          phase_offset,
  input  wire logic                              cosine_select,
  output wire logic signed [wdc_pkg::SAMPLE_W-1:0] wave_out,
  output wire logic                              phase_msb
);
  typedef struct packed {
    logic [23:0] acc;
    logic [13:0] out;
  } wdc_dds_t;

  wdc_dds_t    st;
  wdc_dds_t    next_st;
  logic [15:0] phase;
  logic [14:0] x;
  logic [29:0] prod;
  logic [13:0] mag;

  always_comb begin
    next_st = st;
    next_st.acc = st.acc + tuning_word;
    phase = st.acc[23:8] + phase_offset;
    if (cosine_select) phase = phase + wdc_pkg::COS_SHIFT;
    x = phase[14:0];
    prod = 30'(x) * (30'(wdc_pkg::HALF_TURN) - 30'(x));
    // Parabola peaks one code above full scale, so clip it there
    if (prod[29:15] > 15'h1FFF) mag = 14'h1FFF;
    else mag = prod[28:15];
    next_st.out = phase[15] ? 14'(-mag) : mag;
  end

  always_ff @(posedge CLK) begin
    if (RESET) st <= '0;
    else st <= next_st;
  end

  assign wave_out  = signed'(st.out);
  assign phase_msb = st.acc[23];
endmodule

/* hdl/wdc_top.sv */
/*
 * Waveform generator configuration bank with its output datapath:
 * constant, sawtooth, pseudorandom and synthesizer sources, digital gain,
 * tuning word and phase offset selection, address counter advance.
 * Assumes a simple synchronous register port and pattern memory data
 * presented on MEM_DATA in the same converter clock domain.
 */
`timescale 1ns/1ns

// Functional notes
// - 12-bit constant value, resets to zero
// - Signed 12-bit gain scales samples, range two
// - Ramp holds each level for step samples
// - Shape: up, down, triangle, zero
// - Upper sixteen tuning bits, reset zero
// - Lowest eight tuning bits in upper byte
// - Phase offset from memory or register
// - Tuning word from registers or merged memory
// - Control bit three selects cosine output
// - Address counter on clock or phase MSB
// - Start delay repeats or first pattern only
// - Builtin selector: constant, ramp, noise, synthesizer
// - Shift places memory word in tuning word
module wdc_top (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic        REG_WE,
  input  wire logic        REG_RE,
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  output wire logic [15:0] REG_RDATA,
  input  wire logic [13:0] MEM_DATA,
  output wire logic [13:0] SAMPLE_OUT,
  output wire logic        ADDR_ADVANCE,
  output wire logic        DELAY_FIRST_ONLY,
  output wire logic [23:0] TUNING_WORD
);
  typedef struct packed {
    logic [15:0] wave_cfg;
    logic [15:0] const_val;
    logic [15:0] gain;
    logic [15:0] saw_cfg;
    logic [15:0] tw_high;
    logic [15:0] tw_low;
    logic [15:0] phase_off;
    logic [15:0] trig_cfg;
    logic [15:0] synth_cfg;
    logic [15:0] merge_cfg;
    logic [15:0] rdata;
    logic [13:0] lfsr;
    logic        msb_d;
    logic        advance;
    logic        delay_first;
    logic [23:0] tw_eff;
    logic [15:0] ph_eff;
    logic [13:0] sample;
  } wdc_top_t;

  wdc_top_t st;
  wdc_top_t next_st;

  logic signed [13:0] ramp_level;
  logic signed [13:0] dds_level;
  logic               dds_msb;

  logic [23:0]        tw_regs;
  logic [23:0]        tw_merged;
  logic [23:0]        keep_mask;
  logic [4:0]         shift;
  logic signed [13:0] src;
  logic signed [11:0] gain_factor_field;
  logic signed [25:0] scaled_full;
  logic signed [15:0] scaled;

  wdc_ramp u_ramp (
    .CLK       (CLK),
    .RESET     (RESET),
    .step      (st.saw_cfg[wdc_pkg::STEP_MSB:wdc_pkg::STEP_LSB]),
    .shape     (st.saw_cfg[wdc_pkg::SHAPE_MSB:wdc_pkg::SHAPE_LSB]),
    .level_out (ramp_level)
  );

  wdc_dds u_dds (
    .CLK           (CLK),
    .RESET         (RESET),
    .tuning_word   (st.tw_eff),
    .phase_offset  (st.ph_eff),
    .cosine_select (st.synth_cfg[wdc_pkg::COS_BIT]),
    .wave_out      (dds_level),
    .phase_msb     (dds_msb)
  );

  always_comb begin
    next_st = st;

    // Register writes take effect on the next edge
    if (REG_WE) begin
      case (REG_ADDR)
        wdc_pkg::ADDR_WAVE:  next_st.wave_cfg  = REG_WDATA;
        wdc_pkg::ADDR_CONST: next_st.const_val = REG_WDATA;
        wdc_pkg::ADDR_GAIN:  next_st.gain      = REG_WDATA;
        wdc_pkg::ADDR_SAW:   next_st.saw_cfg   = REG_WDATA;
        wdc_pkg::ADDR_TWH:   next_st.tw_high   = REG_WDATA;
        wdc_pkg::ADDR_TWL:   next_st.tw_low    = REG_WDATA;
        wdc_pkg::ADDR_PHASE: next_st.phase_off = REG_WDATA;
        wdc_pkg::ADDR_TRIG:  next_st.trig_cfg  = REG_WDATA;
        wdc_pkg::ADDR_SYNTH: next_st.synth_cfg = REG_WDATA;
        wdc_pkg::ADDR_MERGE: next_st.merge_cfg = REG_WDATA;
        default: ;
      endcase
    end

    // Read data is captured one edge after the request; a read in the
    // same cycle as a write to that address returns the old value.
    if (REG_RE) begin
      case (REG_ADDR)
        wdc_pkg::ADDR_WAVE:  next_st.rdata = st.wave_cfg;
        wdc_pkg::ADDR_CONST: next_st.rdata = st.const_val;
        wdc_pkg::ADDR_GAIN:  next_st.rdata = st.gain;
        wdc_pkg::ADDR_SAW:   next_st.rdata = st.saw_cfg;
        wdc_pkg::ADDR_TWH:   next_st.rdata = st.tw_high;
        wdc_pkg::ADDR_TWL:   next_st.rdata = st.tw_low;
        wdc_pkg::ADDR_PHASE: next_st.rdata = st.phase_off;
        wdc_pkg::ADDR_TRIG:  next_st.rdata = st.trig_cfg;
        wdc_pkg::ADDR_SYNTH: next_st.rdata = st.synth_cfg;
        wdc_pkg::ADDR_MERGE: next_st.rdata = st.merge_cfg;
        default:             next_st.rdata = 16'h0000;
      endcase
    end

    // Tuning word assembly
    tw_regs = {st.tw_high, st.tw_low[wdc_pkg::TWL_MSB:wdc_pkg::TWL_LSB]};
    shift = st.merge_cfg[wdc_pkg::SHIFT_MSB:wdc_pkg::SHIFT_LSB];
    // Reserved shift codes clamp to the largest valid one
    if (shift > wdc_pkg::MERGE_MAX) shift = wdc_pkg::MERGE_MAX;
    keep_mask = ~(24'hFFFFFF >> shift);
    tw_merged = ({MEM_DATA, 10'h000} >> shift) | (tw_regs & keep_mask);
    if (st.synth_cfg[wdc_pkg::TW_MEM_BIT]) next_st.tw_eff = tw_merged;
    else next_st.tw_eff = tw_regs;

    // Phase offset source; memory words fill the top of the offset
    if (st.synth_cfg[wdc_pkg::PHASE_MEM_BIT]) begin
      next_st.ph_eff = {MEM_DATA, 2'h0};
    end else begin
      next_st.ph_eff = st.phase_off;
    end

    // Address counter advance source
    next_st.msb_d = dds_msb;
    if (st.synth_cfg[wdc_pkg::ADDR_MSB_BIT]) begin
      next_st.advance = dds_msb & ~st.msb_d;
    end else begin
      next_st.advance = 1'b1;
    end

    next_st.delay_first = st.trig_cfg[wdc_pkg::DLY_FIRST_BIT];

    // Pseudorandom source, Galois form
    if (st.lfsr[0]) next_st.lfsr = (st.lfsr >> 1) ^ wdc_pkg::LFSR_TAPS;
    else next_st.lfsr = st.lfsr >> 1;

    // Builtin waveform select
    case (wdc_pkg::wdc_wave_t'(st.wave_cfg[wdc_pkg::BWSEL_MSB:wdc_pkg::BWSEL_LSB]))
      wdc_pkg::WDC_WAVE_CONST:
        src = signed'({st.const_val[wdc_pkg::CONST_MSB:wdc_pkg::CONST_LSB], 2'h0});
      wdc_pkg::WDC_WAVE_RAMP:  src = ramp_level;
      wdc_pkg::WDC_WAVE_NOISE: src = signed'(st.lfsr);
      wdc_pkg::WDC_WAVE_SYNTH: src = dds_level;
      default:                 src = 14'sh0000;
    endcase

    // Gain in two integer bits and ten fraction bits, so 0x400 is unity
    gain_factor_field = signed'(st.gain[wdc_pkg::GAIN_MSB:wdc_pkg::GAIN_LSB]);
    scaled_full = src * gain_factor_field;
    scaled = 16'(scaled_full >>> wdc_pkg::GAIN_FRAC);
    // Saturate rather than wrap so a gain near two cannot flip the sign
    if (scaled > 16'sh1FFF) next_st.sample = 14'h1FFF;
    else if (scaled < -16'sh2000) next_st.sample = 14'h2000;
    else next_st.sample = scaled[13:0];
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st <= '0;
      st.wave_cfg  <= wdc_pkg::RST_WAVE;
      st.const_val <= wdc_pkg::RST_CONST;
      st.gain      <= wdc_pkg::RST_GAIN;
      st.saw_cfg   <= wdc_pkg::RST_SAW;
      st.tw_high   <= wdc_pkg::RST_TWH;
      st.tw_low    <= wdc_pkg::RST_TWL;
      st.phase_off <= wdc_pkg::RST_PHASE;
      st.trig_cfg  <= wdc_pkg::RST_TRIG;
      st.synth_cfg <= wdc_pkg::RST_SYNTH;
      st.merge_cfg <= wdc_pkg::RST_MERGE;
      st.lfsr      <= wdc_pkg::LFSR_SEED;
    end else begin
      st <= next_st;
    end
  end

  assign REG_RDATA        = st.rdata;
  assign SAMPLE_OUT       = st.sample;
  assign ADDR_ADVANCE     = st.advance;
  assign DELAY_FIRST_ONLY = st.delay_first;
  assign TUNING_WORD      = st.tw_eff;
endmodule

/* sim/wdc_top_chk.sv */
/*
 * Port-level checker for wdc_top, bound to every instance.
 * Assumes one clock domain and that only the register port changes the
 * shadowed fields, so the shadows track the design's own registers.
 */
`timescale 1ns/1ns
module wdc_top_chk (
  input logic        CLK,
  input logic        RESET,
  input logic        REG_WE,
  input logic        REG_RE,
  input logic [15:0] REG_ADDR,
  input logic [15:0] REG_WDATA,
  input logic [15:0] REG_RDATA,
  input logic [13:0] MEM_DATA,
  input logic [13:0] SAMPLE_OUT,
  input logic        ADDR_ADVANCE,
  input logic        DELAY_FIRST_ONLY,
  input logic [23:0] TUNING_WORD
);
  typedef struct packed {
    logic        msb;
    logic        twm;
    logic [15:0] twh;
    logic [7:0]  twl;
  } wdc_shadow_t;
  wdc_shadow_t sh;
  wdc_shadow_t next_sh;
  logic        mapped;
  assign mapped = REG_ADDR inside {wdc_pkg::ADDR_WAVE, wdc_pkg::ADDR_CONST, wdc_pkg::ADDR_GAIN,
    wdc_pkg::ADDR_SAW, wdc_pkg::ADDR_TWH, wdc_pkg::ADDR_TWL, wdc_pkg::ADDR_PHASE,
    wdc_pkg::ADDR_TRIG, wdc_pkg::ADDR_SYNTH, wdc_pkg::ADDR_MERGE};
  always_comb begin
    next_sh = sh;
    if (REG_WE && REG_ADDR == wdc_pkg::ADDR_SYNTH) begin
      next_sh.msb = REG_WDATA[wdc_pkg::ADDR_MSB_BIT];
      next_sh.twm = REG_WDATA[wdc_pkg::TW_MEM_BIT];
    end
    if (REG_WE && REG_ADDR == wdc_pkg::ADDR_TWH) begin
      next_sh.twh = REG_WDATA;
    end
    if (REG_WE && REG_ADDR == wdc_pkg::ADDR_TWL) begin
      next_sh.twl = REG_WDATA[15:8];
    end
    if (RESET) begin
      next_sh = '0;
    end
  end
  always_ff @(posedge CLK) begin
    sh <= next_sh;
  end
  default clocking dc @(posedge CLK); endclocking
  default disable iff (RESET);
  reset_outputs_zero_a: assert property (
    $fell(RESET) |-> REG_RDATA == 16'h0000 && SAMPLE_OUT == 14'h0000
      && TUNING_WORD == 24'h000000 && !ADDR_ADVANCE) else $error("output not zero after reset");
  read_back_a: assert property (
    REG_WE && !REG_RE && mapped ##1 !REG_WE && !REG_RE ##1 REG_RE && !REG_WE
      && REG_ADDR == $past(REG_ADDR, 2)
      |=> REG_RDATA == $past(REG_WDATA, 3)) else $error("read data differs from written word");
  unmapped_zero_a: assert property (
    REG_RE && !mapped |=> REG_RDATA == 16'h0000) else $error("unmapped read not zero");
  rdata_holds_a: assert property (
    !REG_RE |=> $stable(REG_RDATA)) else $error("read data moved without a read");
  clock_advance_a: assert property (
    !$past(RESET) && !$past(sh.msb) |-> ADDR_ADVANCE) else $error("advance low on clock source");
  msb_pulse_a: assert property (
    sh.msb && $past(sh.msb) && ADDR_ADVANCE |=> !ADDR_ADVANCE) else $error("advance pulse too long");
  delay_copy_a: assert property (
    REG_WE && REG_ADDR == wdc_pkg::ADDR_TRIG ##1 !(REG_WE && REG_ADDR == wdc_pkg::ADDR_TRIG)
      |=> DELAY_FIRST_ONLY == $past(REG_WDATA[1], 2)) else $error("delay mode bit not copied");
  tuning_regs_a: assert property (
    !$past(RESET) && !$past(sh.twm) |-> TUNING_WORD == {$past(sh.twh), $past(sh.twl)})
    else $error("tuning word not taken from registers");
endmodule
bind wdc_top wdc_top_chk i_wdc_top_chk (.CLK(CLK), .RESET(RESET), .REG_WE(REG_WE),
  .REG_RE(REG_RE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
  .MEM_DATA(MEM_DATA), .SAMPLE_OUT(SAMPLE_OUT), .ADDR_ADVANCE(ADDR_ADVANCE),
  .DELAY_FIRST_ONLY(DELAY_FIRST_ONLY), .TUNING_WORD(TUNING_WORD));

/* sim/wdc_top_test.sv */
/*
 * Self-checking bench for wdc_top with a register and datapath model.
 * Assumes the checker binds itself; inputs move 1 ns after CLK rises.
 */
`timescale 1ns/1ns
module wdc_top_test;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [13:0] mem_data = 14'h0000;
  logic [15:0] reg_rdata;
  logic [13:0] sample_out;
  logic        addr_advance;
  logic        delay_first_only;
  logic [23:0] tuning_word;
  logic [15:0] mdl [logic [15:0]];
  int          n_fail = 0;
  int          samples_checked = 0;
  localparam logic [15:0] MAP [10] = '{16'h0027, 16'h0031, 16'h0035, 16'h0037, 16'h003E,
    16'h003F, 16'h0043, 16'h0044, 16'h0045, 16'h0047};
  localparam logic [15:0] RSTV [10] = '{16'h0101, 16'h0000, 16'h0000, 16'h0104, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] GT [5] = '{16'h4000, 16'h8000, 16'h7FF0, 16'hC000, 16'h0000};

  wdc_top i_wdc_top (.CLK(clk), .RESET(reset), .REG_WE(reg_we), .REG_RE(reg_re),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .MEM_DATA(mem_data),
    .SAMPLE_OUT(sample_out), .ADDR_ADVANCE(addr_advance),
    .DELAY_FIRST_ONLY(delay_first_only), .TUNING_WORD(tuning_word));

  always #5 clk = ~clk;

  task results;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [23:0] e, input logic [23:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task wr(input logic [15:0] a, input logic [15:0] d);
    reg_we = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_we = 1'b0;
    if (mdl.exists(a)) mdl[a] = d;
    // Idle edge so the next strobe never rises in the same step
    tick(1);
  endtask

  task rd(input logic [15:0] a);
    reg_re = 1'b1;
    reg_addr = a;
    tick(1);
    reg_re = 1'b0;
    tick(1);
    chk("rdata", mdl.exists(a) ? mdl[a] : 16'h0000, reg_rdata);
  endtask

  task do_reset;
    reset = 1'b1;
    tick(5);
    reset = 1'b0;
    foreach (MAP[i]) mdl[MAP[i]] = RSTV[i];
    foreach (MAP[i]) rd(MAP[i]);
    rd(16'h0030);
  endtask

  task dds(input logic [15:0] a, input logic [15:0] d, input logic [13:0] e);
    wr(a, d);
    tick(8);
    chk("synth", e, sample_out);
  endtask

  // Saturating gain, field 0x400 is unity
  function automatic logic [13:0] gm(input logic [15:0] c, input logic [15:0] g);
    int p;
    p = $signed({c[15:4], 2'b00}) * $signed(g[15:4]);
    p = p >>> 10;
    if (p > 8191) p = 8191;
    if (p < -8192) p = -8192;
    return p[13:0];
  endfunction

  initial begin
    #300000;
    n_fail++;
    results();
  end

  initial begin
    logic [31:0] r;
    logic [15:0] c;
    logic [13:0] prev;
    logic [13:0] d;
    int          cnt;
    int          m;
    void'($urandom(32'h7761));
    do_reset();
    wr(wdc_pkg::ADDR_GAIN, 16'h4000);
    wr(wdc_pkg::ADDR_WAVE, 16'h0131);
    dds(wdc_pkg::ADDR_SYNTH, 16'h0000, 14'h0000);
    dds(wdc_pkg::ADDR_SYNTH, 16'h0008, 14'h1FFF);
    dds(wdc_pkg::ADDR_SYNTH, 16'h0000, 14'h0000);
    dds(wdc_pkg::ADDR_PHASE, 16'hC000, 14'h2001);
    mem_data = 14'h1000;
    dds(wdc_pkg::ADDR_SYNTH, 16'h0002, 14'h1FFF);
    wr(wdc_pkg::ADDR_SYNTH, 16'h0004);
    wr(wdc_pkg::ADDR_TWH, 16'h4000);
    tick(4);
    cnt = 0;
    repeat (40) begin
      tick(1);
      cnt += addr_advance;
    end
    chk("advance count", 24'd10, 24'(cnt));
    r = $urandom;
    wr(wdc_pkg::ADDR_TWH, r[15:0]);
    wr(wdc_pkg::ADDR_TWL, r[31:16]);
    wr(wdc_pkg::ADDR_SYNTH, 16'h0000);
    tick(2);
    chk("tuning", {r[15:0], r[31:24]}, tuning_word);
    mem_data = 14'($urandom);
    wr(wdc_pkg::ADDR_SYNTH, 16'h0001);
    for (int s = 0; s < 19; s++) begin
      wr(wdc_pkg::ADDR_MERGE, 16'(s));
      tick(2);
      m = s > 16 ? 16 : s;
      chk("merge", ({mem_data, 10'h000} >> m) | ({r[15:0], r[31:24]} & ~(24'hFFFFFF >> m)),
        tuning_word);
    end
    wr(wdc_pkg::ADDR_WAVE, 16'h0101);
    for (int i = 0; i < 12; i++) begin
      c = 16'($urandom);
      wr(wdc_pkg::ADDR_CONST, c);
      wr(wdc_pkg::ADDR_GAIN, i < 5 ? GT[i] : 16'($urandom));
      tick(3);
      chk("sample", gm(c, mdl[wdc_pkg::ADDR_GAIN]), sample_out);
    end
    wr(wdc_pkg::ADDR_GAIN, 16'h4000);
    wr(wdc_pkg::ADDR_WAVE, 16'h0111);
    for (int sh = 0; sh < 3; sh++) begin
      wr(wdc_pkg::ADDR_SAW, {8'h01, 6'(2 + 3 * sh), 2'(sh)});
      tick(20);
      cnt = 0;
      prev = sample_out;
      repeat (60) begin
        tick(1);
        d = 14'(sample_out - prev);
        if (sample_out !== prev) begin
          cnt++;
          chk("ramp delta", sh == 1 ? 14'h3FFF : 14'h0001, d);
        end
        prev = sample_out;
      end
      if (sh < 2) chk("ramp count", 24'(60 / (2 + 3 * sh)), 24'(cnt));
    end
    wr(wdc_pkg::ADDR_SAW, 16'h0107);
    tick(4);
    chk("ramp zero", 14'h0000, sample_out);
    wr(wdc_pkg::ADDR_WAVE, 16'h0121);
    tick(3);
    repeat (20) begin
      prev = sample_out;
      tick(1);
      d = prev[0] ? (prev >> 1) ^ wdc_pkg::LFSR_TAPS : prev >> 1;
      chk("noise", d, sample_out);
    end
    for (int b = 0; b < 2; b++) begin
      wr(wdc_pkg::ADDR_TRIG, b ? 16'hFFFD : 16'h0002);
      tick(2);
      chk("delay mode", 24'(1 - b), delay_first_only);
    end
    for (int i = 0; i < 12; i++) begin
      wr(i < 10 ? MAP[i] : 16'h0030 + 16'(i), 16'($urandom));
      rd(i < 10 ? MAP[i] : 16'h0030 + 16'(i));
    end
    do_reset();
    results();
  end
endmodule
